/* File: gauge_pkg.sv */
// Constants and types shared by the charge-accounting core.
// Assumes the converter words arrive in millivolts on the core clock.
package gauge_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROG_CAP = 8'h04;
  localparam logic [7:0] OFS_EARLY_THR = 8'h08;
  localparam logic [7:0] OFS_FINAL_THR = 8'h0C;
  localparam logic [7:0] OFS_MAX_THR = 8'h10;
  localparam logic [7:0] OFS_AVAIL = 8'h14;
  localparam logic [7:0] OFS_TALLY = 8'h18;
  localparam logic [7:0] OFS_LEARNED = 8'h1C;
  localparam logic [7:0] OFS_VOLTAGE = 8'h20;
  localparam logic [7:0] OFS_TEMP = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // Control register fields.
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_SCALE_LSB = 1;
  localparam int CTRL_DISP_BIT = 3;

  // Status register fields.
  localparam int ST_EARLY = 0;
  localparam int ST_FINAL = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_PRESENT = 4;
  localparam int ST_MONITOR = 5;
  localparam int ST_QUAL = 6;

  // Voltage levels in millivolts.
  localparam logic [11:0] EARLY_THR_RST = 12'h041A;
  localparam logic [11:0] FINAL_THR_RST = 12'h03B6;
  localparam logic [11:0] MAX_THR_RST = 12'h08CA;
  localparam logic [11:0] PRESENT_MV = 12'h0064;
  localparam logic [11:0] RESTART_MV = 12'h00FA;
  localparam logic signed [11:0] HEAVY_MV = -12'sd250;

  localparam logic [15:0] PROG_CAP_RST = 16'h8400;
  localparam logic [15:0] TALLY_MAX = 16'hFFFF;
  localparam logic [15:0] BASE_STEP = 16'h0002;
  localparam logic [1:0] SCALE_RST = 2'h0;
  localparam logic [3:0] TEMP_BAND_MAX = 4'hC;
  localparam logic [3:0] COLD_BAND = 4'h4;
  localparam logic [6:0] FULL_PERCENT = 7'h64;

  // Monitoring holdoff after heavy discharge.
  localparam int HOLDOFF_MS = 500;
  localparam int CLK_MHZ = 200;
  localparam int HOLDOFF_CYC = HOLDOFF_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic charge;
    logic discharge;
    logic self_discharge;
    logic fast_rate;
  } count_events_t;

  typedef struct packed {
    logic [15:0] avail;
    logic [15:0] tally;
    logic [15:0] learned;
    logic [15:0] prog;
    logic [11:0] early_thr;
    logic [11:0] final_thr;
    logic [11:0] max_thr;
    logic [11:0] volt_prev;
    logic [1:0] scale;
    logic disp_en;
    logic early_f;
    logic final_f;
    logic empty_f;
    logic qual;
    logic dir_up;
    logic monitor_on;
    logic [26:0] holdoff;
    logic present;
    logic fault;
    logic valid_pulse;
    logic [6:0] percent;
    logic [31:0] prdata;
    logic pslverr;
    logic [1:0] btn_sync;
  } state_t;

endpackage : gauge_pkg

/* File: charge_accounting_core.sv */
// Charge-accounting core of a battery gas gauge with an APB register port.
// Assumes converter words and count events are synchronous to clk.
//
// Overview of operation
// - Cell under either threshold latches its flag until valid charge.
// - Heavy discharge halts threshold checks until half a second after.
// - Empty output floats once final flag latches, until valid charge.
// - Battery counts as present whenever cell voltage exceeds 0.1 V.
// - Voltage rising past 0.25 V or falling past 2.25 V resets the core.
// - A host reset command resets the core without any voltage change.
// - Temperature reading holds a 10-degree band in its upper hex digit.
// - Temperature band steers compensation of charge, discharge and self-discharge.
// - Charging with cell voltage above maximum threshold raises a fault.
// - Charge adds to available count; discharges subtract, grow tally.
// - Rate and temperature cut counts; self-discharge only temperature.
// - Tally becomes capacity after unbroken full-to-early discharge.
// - Charge stops at reference: programmed count until one is learned.
// - Valid charge only on a carry from the low into the high byte.
// - Low byte clears when counting turns from down to up.
// - Each increment adds 2, 4, 8 or 16 counts by scale selection.
// - Learned capacity takes programmed count at power-up and pack swap.
// - Display percentage uses learned capacity as the full reference.
// - Push-button input momentarily enables the charge display.
// - Host can read the measured cell voltage level.
// - Available count zeroes at init and first valid charge after warning.
// - Tally saturates at FFFFh, clears when available equals learned.
`timescale 1ns/1ps
`default_nettype none

module charge_accounting_core #(
  parameter int unsigned HOLDOFF_CYCLES = gauge_pkg::HOLDOFF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] cell_voltage_level,
  input wire logic signed [11:0] sense_resistor_input,
  input wire logic signed [7:0] temperature_c,
  input wire gauge_pkg::count_events_t events,
  input wire logic display_button_n,
  output logic empty_o,
  output logic empty_oe,
  output logic display_on,
  output logic [6:0] display_percent,
  output logic fault,
  output logic valid_charge
);

  gauge_pkg::state_t s_q;
  gauge_pkg::state_t s_d;

  // Band code: 0 below -30 C, one step per 10 C, 12 from 80 C up.
  function automatic logic [3:0] temp_band(input logic signed [7:0] t);
    logic signed [9:0] shifted;
    logic [9:0] idx;
    shifted = 10'(t) + 10'sd40;
    if (shifted < 10'sd10)
      temp_band = 4'h0;
    else
    begin
      idx = 10'(shifted / 10'sd10);
      temp_band = (idx > 10'(gauge_pkg::TEMP_BAND_MAX))
        ? gauge_pkg::TEMP_BAND_MAX : idx[3:0];
    end
  endfunction : temp_band

  // Cold cells lose an eighth of each step, fast rates a further quarter.
  function automatic logic [15:0] compensate(input logic [15:0] step,
                                             input logic [3:0] band,
                                             input logic fast);
    logic [15:0] cut;
    cut = 16'h0000;
    if (band < gauge_pkg::COLD_BAND)
      cut = step >> 3;
    if (fast)
      cut = cut + (step >> 2);
    compensate = step - cut;
  endfunction : compensate

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a <= gauge_pkg::OFS_STATUS) && (a[1:0] == 2'h0);
  endfunction : addr_mapped

  logic [3:0] band;
  logic [15:0] step;
  logic [15:0] chg_step;
  logic [15:0] dis_step;
  logic [15:0] self_step;
  logic [15:0] up_base;
  logic [16:0] up_sum;
  logic [15:0] up_val;
  logic [15:0] dec;
  logic heavy;
  logic below_restart;
  logic soft_reset;
  logic wr;
  logic rd_setup;
  logic early_hit;
  logic [31:0] status_word;
  logic [22:0] pct_wide;

  always_comb
  begin
    s_d = s_q;
    s_d.valid_pulse = 1'b0;
    s_d.btn_sync = {s_q.btn_sync[0], ~display_button_n};
    s_d.volt_prev = cell_voltage_level;

    band = temp_band(temperature_c);
    step = gauge_pkg::BASE_STEP << s_q.scale;
    chg_step = compensate(step, band, events.fast_rate);
    dis_step = compensate(step, band, events.fast_rate);
    self_step = compensate(step, band, 1'b0);

    wr = psel && penable && pwrite && addr_mapped(paddr);
    rd_setup = psel && !penable;
    heavy = sense_resistor_input <= gauge_pkg::HEAVY_MV;
    below_restart = s_q.volt_prev < gauge_pkg::RESTART_MV;

    soft_reset = (below_restart
                  && cell_voltage_level >= gauge_pkg::RESTART_MV)
      || (s_q.volt_prev > gauge_pkg::MAX_THR_RST
          && cell_voltage_level <= gauge_pkg::MAX_THR_RST)
      || (wr && paddr == gauge_pkg::OFS_CTRL
          && pwdata[gauge_pkg::CTRL_RESET_BIT]);

    s_d.present = cell_voltage_level > gauge_pkg::PRESENT_MV;

    if (heavy)
    begin
      s_d.monitor_on = 1'b0;
      s_d.holdoff = 27'h000_0000;
    end
    else if (!s_q.monitor_on)
    begin
      if (32'(s_q.holdoff) >= HOLDOFF_CYCLES - 1)
        s_d.monitor_on = 1'b1;
      else
        s_d.holdoff = s_q.holdoff + 27'h000_0001;
    end

    up_base = s_q.dir_up ? s_q.avail : {s_q.avail[15:8], 8'h00};
    up_sum = {1'b0, up_base} + {1'b0, chg_step};
    up_val = (up_sum >= {1'b0, s_q.learned}) ? s_q.learned : up_sum[15:0];
    early_hit = 1'b0;
    dec = events.discharge ? dis_step : self_step;

    s_d.fault = events.charge
      && cell_voltage_level > s_q.max_thr;

    if (events.charge && s_q.avail < s_q.learned)
    begin
      s_d.avail = up_val;
      s_d.dir_up = 1'b1;
      s_d.qual = 1'b0;
      if (up_val[15:8] != up_base[15:8])
      begin
        s_d.valid_pulse = 1'b1;
        if (s_q.early_f)
          s_d.avail = 16'h0000;
        s_d.early_f = 1'b0;
        s_d.final_f = 1'b0;
        s_d.empty_f = 1'b0;
      end
    end
    else if (events.discharge || events.self_discharge)
    begin
      s_d.avail = (s_q.avail > dec) ? s_q.avail - dec : 16'h0000;
      s_d.dir_up = 1'b0;
      if ((events.discharge || s_q.avail != 16'h0000) && !s_q.early_f)
        s_d.tally = (32'(s_q.tally) + 32'(dec) > 32'(gauge_pkg::TALLY_MAX))
          ? gauge_pkg::TALLY_MAX : s_q.tally + dec;
    end

    if (s_d.avail == s_q.learned && !events.discharge
        && !events.self_discharge)
    begin
      s_d.tally = 16'h0000;
      s_d.qual = 1'b1;
    end

    if (s_q.monitor_on && s_q.present && !heavy)
    begin
      if (cell_voltage_level < s_q.early_thr && !s_q.early_f)
      begin
        s_d.early_f = 1'b1;
        early_hit = 1'b1;
      end
      if (cell_voltage_level < s_q.final_thr)
      begin
        s_d.final_f = 1'b1;
        s_d.empty_f = 1'b1;
      end
    end

    if (early_hit && s_q.qual)
    begin
      s_d.learned = s_q.tally;
      s_d.qual = 1'b0;
    end

    if (s_d.present && !s_q.present)
      s_d.learned = s_q.prog;

    pct_wide = 23'(s_q.avail) * 23'(gauge_pkg::FULL_PERCENT);
    if (s_q.learned == 16'h0000)
      s_d.percent = 7'h00;
    else
      s_d.percent = 7'(pct_wide / 23'(s_q.learned));

    // Software register writes.
    if (wr)
    begin
      unique case (paddr)
        gauge_pkg::OFS_CTRL:
        begin
          s_d.scale = pwdata[gauge_pkg::CTRL_SCALE_LSB +: 2];
          s_d.disp_en = pwdata[gauge_pkg::CTRL_DISP_BIT];
        end
        gauge_pkg::OFS_PROG_CAP: s_d.prog = pwdata[15:0];
        gauge_pkg::OFS_EARLY_THR: s_d.early_thr = pwdata[11:0];
        gauge_pkg::OFS_FINAL_THR: s_d.final_thr = pwdata[11:0];
        gauge_pkg::OFS_MAX_THR: s_d.max_thr = pwdata[11:0];
        default: s_d.scale = s_d.scale;
      endcase
    end

    status_word = 32'h0000_0000;
    status_word[gauge_pkg::ST_EARLY] = s_q.early_f;
    status_word[gauge_pkg::ST_FINAL] = s_q.final_f;
    status_word[gauge_pkg::ST_EMPTY] = s_q.empty_f;
    status_word[gauge_pkg::ST_FAULT] = s_q.fault;
    status_word[gauge_pkg::ST_PRESENT] = s_q.present;
    status_word[gauge_pkg::ST_MONITOR] = s_q.monitor_on;
    status_word[gauge_pkg::ST_QUAL] = s_q.qual;

    // Read data is captured in the setup phase so it is stable in access.
    if (rd_setup)
    begin
      s_d.pslverr = !addr_mapped(paddr);
      unique case (paddr)
        gauge_pkg::OFS_CTRL:
          s_d.prdata = {28'h000_0000, s_q.disp_en, s_q.scale, 1'b0};
        gauge_pkg::OFS_PROG_CAP: s_d.prdata = {16'h0000, s_q.prog};
        gauge_pkg::OFS_EARLY_THR: s_d.prdata = {20'h0_0000, s_q.early_thr};
        gauge_pkg::OFS_FINAL_THR: s_d.prdata = {20'h0_0000, s_q.final_thr};
        gauge_pkg::OFS_MAX_THR: s_d.prdata = {20'h0_0000, s_q.max_thr};
        gauge_pkg::OFS_AVAIL: s_d.prdata = {16'h0000, s_q.avail};
        gauge_pkg::OFS_TALLY: s_d.prdata = {16'h0000, s_q.tally};
        gauge_pkg::OFS_LEARNED: s_d.prdata = {16'h0000, s_q.learned};
        gauge_pkg::OFS_VOLTAGE: s_d.prdata = {20'h0_0000, s_q.volt_prev};
        gauge_pkg::OFS_TEMP: s_d.prdata = {24'h00_0000, band, 4'h0};
        gauge_pkg::OFS_STATUS: s_d.prdata = status_word;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // A restart clears the accounting but keeps programmed settings.
    if (soft_reset)
    begin
      s_d.avail = 16'h0000;
      s_d.tally = 16'h0000;
      s_d.learned = s_q.prog;
      s_d.early_f = 1'b0;
      s_d.final_f = 1'b0;
      s_d.empty_f = 1'b0;
      s_d.qual = 1'b0;
      s_d.dir_up = 1'b0;
      s_d.valid_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.prog <= gauge_pkg::PROG_CAP_RST;
      s_q.learned <= gauge_pkg::PROG_CAP_RST;
      s_q.early_thr <= gauge_pkg::EARLY_THR_RST;
      s_q.final_thr <= gauge_pkg::FINAL_THR_RST;
      s_q.max_thr <= gauge_pkg::MAX_THR_RST;
      s_q.scale <= gauge_pkg::SCALE_RST;
      s_q.monitor_on <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = s_q.pslverr && psel && penable;
  // Open drain: pulled low until empty, then released.
  assign empty_o = 1'b0;
  assign empty_oe = !s_q.empty_f;
  assign display_on = s_q.disp_en || s_q.btn_sync[1];
  assign display_percent = s_q.percent;
  assign fault = s_q.fault;
  assign valid_charge = s_q.valid_pulse;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  empty_release_a: assert property (
    s_q.monitor_on && s_q.present && !heavy && !soft_reset
    && cell_voltage_level < s_q.final_thr |=> !empty_oe)
    else $error("empty output not released");
  empty_hold_a: assert property (
    s_q.final_f && !soft_reset |=> s_q.final_f || s_q.valid_pulse)
    else $error("final flag dropped without charge");
  early_hold_a: assert property (
    s_q.early_f && !soft_reset |=> s_q.early_f || s_q.valid_pulse)
    else $error("early flag dropped");
  heavy_block_a: assert property (
    heavy |=> !s_q.monitor_on)
    else $error("monitor still on in heavy discharge");
  resume_late_a: assert property (
    !$past(reset) && $rose(s_q.monitor_on)
    |-> $past(!heavy) && $past(!heavy, 2))
    else $error("monitoring resumed early");
  present_lvl_a: assert property (
    !$past(reset) |-> s_q.present
    == ($past(cell_voltage_level) > gauge_pkg::PRESENT_MV))
    else $error("presence wrong");
  avail_cap_a: assert property (
    events.charge |=> s_q.avail <= $past(s_q.learned)
    || s_q.avail == $past(s_q.avail))
    else $error("available above capacity");
  tally_sat_a: assert property (
    s_q.tally == gauge_pkg::TALLY_MAX && !$changed(s_q.avail)
    |=> s_q.tally != 16'h0000 || s_q.avail == s_q.learned || $past(soft_reset))
    else $error("tally wrapped");
  fault_lvl_a: assert property (
    events.charge && cell_voltage_level > s_q.max_thr |=> fault)
    else $error("fault missed");
  valid_pulse_a: assert property (
    valid_charge |-> $past(events.charge) && s_q.dir_up)
    else $error("valid charge without charging");
  host_reset_a: assert property (
    wr && paddr == gauge_pkg::OFS_CTRL && pwdata[0] |=>
    s_q.avail == 16'h0000 && s_q.learned == s_q.prog)
    else $error("host reset ignored");

  learn_cov: cover property ($changed(s_q.learned) && !$past(soft_reset));
  empty_cov: cover property ($rose(s_q.empty_f));
  valid_cov: cover property (valid_charge ##[1:100] s_q.early_f);
  holdoff_cov: cover property ($rose(s_q.monitor_on));

endmodule : charge_accounting_core

`default_nettype wire

/* File: battery_pack_model.sv */
// Far-side model: a cell pack seen through the divider and sense resistor.
// Assumes the bench sets the levels just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

module battery_pack_model (
  input wire logic clk,
  input wire logic [11:0] cell_mv,
  input wire logic signed [11:0] sense_mv,
  input wire logic signed [7:0] temp_c,
  output logic [11:0] cell_voltage_level,
  output logic signed [11:0] sense_resistor_input,
  output logic signed [7:0] temperature_c
);

  // The words are registered, as a sampled converter would deliver them.
  // A level set by the bench therefore reaches the core one clock later.
  always_ff @(posedge clk)
  begin
    cell_voltage_level <= cell_mv;
    sense_resistor_input <= sense_mv;
    temperature_c <= temp_c;
  end

endmodule : battery_pack_model

`default_nettype wire

/* File: test_battery_charge_accounting_core.sv */
// Self-checking bench for the charge-accounting core.
// Assumes the core and the pack model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module test_battery_charge_accounting_core;
  typedef struct {
    int kind;
    logic fast;
    int temp;
    int d_avail;
    int d_tally;
  } step_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] cell_mv = 12'h04B0;
  logic signed [11:0] sense_mv = 12'h000;
  logic signed [7:0] temp_c = 8'h19;
  logic [11:0] cell_voltage_level;
  logic signed [11:0] sense_resistor_input;
  logic signed [7:0] temperature_c;
  gauge_pkg::count_events_t events = '0;
  logic display_button_n = 1'b1;
  logic empty_o;
  logic empty_oe;
  logic display_on;
  logic fault;
  logic valid_charge;
  logic [6:0] display_percent;
  int miscompares = 0;
  int n_tests = 0;
  int n_valid = 0;
  int cycles = 0;
  int n;
  int exp_avail;
  int exp_tally;
  logic [31:0] r;
  logic e;
  // Scale 3 gives a step of 16; 25 C is a warm band, -5 C a cold one.
  step_row_t rows [8] = '{'{0, 1'b0, 25, 16, 0}, '{0, 1'b1, 25, 12, 0},
    '{0, 1'b0, -5, 14, 0}, '{0, 1'b1, -5, 10, 0},
    '{1, 1'b0, 25, -16, 16}, '{1, 1'b1, 25, -12, 12},
    '{2, 1'b1, 25, -16, 16}, '{2, 1'b0, -5, -14, 14}};

  charge_accounting_core #(.HOLDOFF_CYCLES(16)) charge_accounting_core_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .cell_voltage_level(cell_voltage_level),
    .sense_resistor_input(sense_resistor_input),
    .temperature_c(temperature_c), .events(events),
    .display_button_n(display_button_n), .empty_o(empty_o),
    .empty_oe(empty_oe), .display_on(display_on),
    .display_percent(display_percent), .fault(fault),
    .valid_charge(valid_charge));

  battery_pack_model battery_pack_model_i (
    .clk(clk), .cell_mv(cell_mv), .sense_mv(sense_mv), .temp_c(temp_c),
    .cell_voltage_level(cell_voltage_level),
    .sense_resistor_input(sense_resistor_input),
    .temperature_c(temperature_c));

  always #2.5 clk = ~clk;

  // Valid-charge pulses are counted at the falling edge, once settled.
  always @(negedge clk)
  begin
    if (valid_charge === 1'b1)
      n_valid++;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Starting at an edge keeps two transfers from sharing one time step.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never completes.
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask : rd

  task automatic sbit(input int b, input logic exp);
    apb(1'b0, gauge_pkg::OFS_STATUS, 32'h0000_0000);
    chk(32'(r[b]), 32'(exp));
  endtask : sbit

  task automatic pulse(input int kind, input logic fast);
    @(posedge clk);
    events <= '{charge: kind == 0, discharge: kind == 1,
                self_discharge: kind == 2, fast_rate: fast};
    @(posedge clk);
    events <= '0;
    @(posedge clk);
  endtask : pulse

  task automatic charge_to_valid(output int cnt);
    int v;
    v = n_valid;
    cnt = 0;
    while (n_valid == v && cnt < 300)
    begin
      pulse(0, 1'b0);
      @(posedge clk);
      cnt++;
    end
  endtask : charge_to_valid

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(32'({empty_o, empty_oe, display_on, fault, valid_charge}),
        32'h0000_0008);
    chk(32'(display_percent), 32'h0000_0000);
    rd(gauge_pkg::OFS_PROG_CAP, 32'h0000_8400);
    rd(gauge_pkg::OFS_LEARNED, 32'h0000_8400);
    rd(gauge_pkg::OFS_EARLY_THR, 32'h0000_041A);
    rd(gauge_pkg::OFS_FINAL_THR, 32'h0000_03B6);
    rd(gauge_pkg::OFS_MAX_THR, 32'h0000_08CA);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0000);
    rd(gauge_pkg::OFS_VOLTAGE, 32'h0000_04B0);
    sbit(gauge_pkg::ST_PRESENT, 1'b1);
    for (int k = 0; k < 13; k++)
    begin
      temp_c <= 8'(k * 10 - 35);
      repeat (4) @(posedge clk);
      rd(gauge_pkg::OFS_TEMP, 32'(k) << 4);
    end
    temp_c <= 8'h19;
    charge_to_valid(n);
    chk(32'(n), 32'h0000_0080);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0100);
    apb(1'b1, gauge_pkg::OFS_CTRL, 32'h0000_0006);
    exp_avail = 256;
    exp_tally = 0;
    foreach (rows[i])
    begin
      temp_c <= 8'(rows[i].temp);
      repeat (4) @(posedge clk);
      pulse(rows[i].kind, rows[i].fast);
      exp_avail += rows[i].d_avail;
      exp_tally += rows[i].d_tally;
      rd(gauge_pkg::OFS_AVAIL, 32'(exp_avail));
      rd(gauge_pkg::OFS_TALLY, 32'(exp_tally));
    end
    temp_c <= 8'h19;
    apb(1'b1, gauge_pkg::OFS_CTRL, 32'h0000_0000);
    charge_to_valid(n);
    chk(32'(n), 32'h0000_0080);
    cell_mv <= 12'h0032;
    repeat (4) @(posedge clk);
    sbit(gauge_pkg::ST_PRESENT, 1'b0);
    cell_mv <= 12'h04B0;
    repeat (4) @(posedge clk);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0000);
    rd(gauge_pkg::OFS_TALLY, 32'h0000_0000);
    cell_mv <= 12'h08FC;
    repeat (4) @(posedge clk);
    // The fault level stands for one cycle only, so look inside that cycle.
    @(posedge clk);
    events <= '{charge: 1'b1, discharge: 1'b0, self_discharge: 1'b0,
                fast_rate: 1'b0};
    @(posedge clk);
    events <= '0;
    @(negedge clk);
    chk(32'(fault), 32'h0000_0001);
    @(posedge clk);
    cell_mv <= 12'h04B0;
    repeat (4) @(posedge clk);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0000);
    sense_mv <= -12'sd300;
    repeat (4) @(posedge clk);
    cell_mv <= 12'h0384;
    repeat (8) @(posedge clk);
    sbit(gauge_pkg::ST_EARLY, 1'b0);
    sense_mv <= 12'h000;
    repeat (8) @(posedge clk);
    chk(32'(empty_oe), 32'h0000_0001);
    repeat (24) @(posedge clk);
    chk(32'(empty_oe), 32'h0000_0000);
    sbit(gauge_pkg::ST_EARLY, 1'b1);
    cell_mv <= 12'h04B0;
    repeat (4) @(posedge clk);
    sbit(gauge_pkg::ST_FINAL, 1'b1);
    chk(32'(empty_oe), 32'h0000_0000);
    charge_to_valid(n);
    chk(32'(n), 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk(32'(empty_oe), 32'h0000_0001);
    sbit(gauge_pkg::ST_EARLY, 1'b0);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0000);
    pulse(0, 1'b0);
    apb(1'b1, gauge_pkg::OFS_PROG_CAP, 32'h0000_0120);
    apb(1'b1, gauge_pkg::OFS_CTRL, 32'h0000_0001);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0000);
    rd(gauge_pkg::OFS_LEARNED, 32'h0000_0120);
    apb(1'b1, gauge_pkg::OFS_CTRL, 32'h0000_0006);
    repeat (20) pulse(0, 1'b0);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0120);
    chk(32'(display_percent), 32'h0000_0064);
    pulse(1, 1'b0);
    rd(gauge_pkg::OFS_TALLY, 32'h0000_0010);
    chk(32'(display_percent), 32'h0000_005E);
    repeat (4) pulse(0, 1'b0);
    rd(gauge_pkg::OFS_TALLY, 32'h0000_0000);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0120);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    chk(r, 32'h0000_0000);
    apb(1'b1, gauge_pkg::OFS_AVAIL, 32'h0000_1234);
    rd(gauge_pkg::OFS_AVAIL, 32'h0000_0120);
    display_button_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(display_on), 32'h0000_0001);
    display_button_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(display_on), 32'h0000_0000);
    // Scale 3 as well, so the saturation run below stays short.
    apb(1'b1, gauge_pkg::OFS_CTRL, 32'h0000_000E);
    repeat (2) @(posedge clk);
    chk(32'(display_on), 32'h0000_0001);
    // A steady discharge of 16 a cycle passes FFFFh after 4096 cycles.
    events <= '{charge: 1'b0, discharge: 1'b1, self_discharge: 1'b0,
                fast_rate: 1'b0};
    repeat (4100) @(posedge clk);
    events <= '0;
    rd(gauge_pkg::OFS_TALLY, 32'h0000_FFFF);
    report_and_stop();
  end

endmodule : test_battery_charge_accounting_core

`default_nettype wire
